// ---- verilog/omc_pkg.sv ----
// shared constants and mode encoding for the operating-mode controller
package omc_pkg;

  // operating modes, binary codes written out
  typedef enum logic [2:0]
  {
    OMC_NOT_POWERED = 3'h0,
    OMC_POWER_OFF   = 3'h1,
    OMC_ACTIVE      = 3'h2,
    OMC_IDLE        = 3'h3,
    OMC_CONNECTED   = 3'h4
  } omc_mode_t;

  // power saving setting values
  localparam logic [1:0] PSV_OFF      = 2'h0;
  localparam logic [1:0] PSV_PERIODIC = 2'h1;
  localparam logic [1:0] PSV_RTS      = 2'h2;
  localparam logic [1:0] PSV_DTR      = 2'h3;

  // flow control setting value that turns hardware flow control off
  localparam logic [1:0] FLOW_OFF = 2'h3;

  // register offsets of the plain register port
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_WAKE   = 4'h2;

  // config register field positions
  localparam int CFG_PSV_LSB  = 0;
  localparam int CFG_FLOW_LSB = 2;

  // reset values
  localparam logic [1:0] PSV_RESET  = 2'h0;
  localparam logic [1:0] FLOW_RESET = 2'h0;

  // status register field positions
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_READY_BIT = 3;
  localparam int ST_CTS_BIT   = 4;
  localparam int ST_FAST_BIT  = 5;

  // wake cause field: one bit per source
  localparam int WAKE_SRC_N = 9;

  // default idle dwell before periodic wake, in mclk cycles
  localparam int PERIOD_DEFAULT = 100000;

endpackage : omc_pkg

// ---- verilog/omc_operating_mode_controller.sv ----
// operating-mode state machine with wake sources and host-side readiness
//
// Contract
// - proper switch-off moves active to power-off
// - switch-on, reset or alarm leave power-off
// - supply loss in power-off gives not-powered
// - interfaces inaccessible while powered off
// - any power-on event enters active mode
// - power saving enabled lets active become idle
// - power saving disabled after power-up
// - idle means not ready for host data
// - CTS shows serial port enabled or disabled
// - periodic wake for paging channel monitoring
// - setting 1 wakes periodically, enables port
// - clock alarm wakes from idle
// - serial data wakes, per flow settings
// - RTS on wakes when flow off, setting 2
// - DTR on wakes with setting 3
// - USB presence wakes from idle
// - USB remote wakeup wakes from idle
// - positioning ready input wakes from idle
// - call start moves active to connected
// - call end returns connected to active
// - active and connected ready unless saving; the code also stays ready with setting 1
// - fast reference active, slow reference idle
// - not-powered ignores switch-on, reset, alarm
//
// The strobed register port and the address map were chosen for this implementation.
module omc_operating_mode_controller
#(
  parameter int PAGING_PERIOD = omc_pkg::PERIOD_DEFAULT
)
(
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // supply and power events (pins)
  input  wire logic        supplyGood,
  input  wire logic        switchOnInput,
  input  wire logic        resetInput_n,
  input  wire logic        slowClockPresent,
  // internal events (same clock)
  input  wire logic        switchOffReq,
  input  wire logic        rtcAlarm,
  input  wire logic        callStart,
  input  wire logic        callEnd,
  input  wire logic        activityBusy,
  input  wire logic        uartRxData,
  input  wire logic        usbRemoteWakeup,
  // host lines (pins)
  input  wire logic        rtsOn,
  input  wire logic        dtrOn,
  input  wire logic        usbPresenceInput,
  input  wire logic        positioningReadyInput,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // status outputs
  output logic      [2:0]  mode,
  output logic             ifReady,
  output logic             ctsOn,
  output logic             fastClockSel
);

  omc_pkg::omc_mode_t state;
  omc_pkg::omc_mode_t next_state;
  logic [1:0]  powerSaving;
  logic [1:0]  flowControl;
  logic [31:0] idleCount;
  logic        periodicWake;
  logic [omc_pkg::WAKE_SRC_N-1:0] wakeSrc;
  logic [omc_pkg::WAKE_SRC_N-1:0] wakeCause;

  // three-stage synchronisers for pin inputs
  localparam int NPIN = 7;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] syncA;
  logic [NPIN-1:0] syncB;
  logic [NPIN-1:0] syncC;
  logic [NPIN-1:0] pinStable;

  // reset input is inverted so every synced line is active high
  assign pinRaw = {positioningReadyInput, usbPresenceInput, dtrOn, rtsOn,
                   ~resetInput_n, switchOnInput, supplyGood};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end
    else if (clkEn)
    begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (srst)
      pinStable <= '0;
    else if (clkEn)
    begin
      for (int i = 0; i < NPIN; i++)
      begin
        if (syncB[i] == syncC[i])
          pinStable[i] <= syncC[i];
      end
    end
  end

  logic sSupply;
  logic sSwitchOn;
  logic sReset;
  logic sRts;
  logic sDtr;
  logic sUsbPres;
  logic sPosReady;
  assign sSupply   = pinStable[0];
  assign sSwitchOn = pinStable[1];
  assign sReset    = pinStable[2];
  assign sRts      = pinStable[3];
  assign sDtr      = pinStable[4];
  assign sUsbPres  = pinStable[5];
  assign sPosReady = pinStable[6];

  function automatic logic savingOn(input logic [1:0] psv);
    savingOn = (psv != omc_pkg::PSV_OFF);
  endfunction : savingOn

  // strobe qualified by one register offset
  function automatic logic regHit(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
    regHit = strobe && (addr == target);
  endfunction : regHit

  // active and connected both run on the fast reference
  function automatic logic isRunning(input omc_pkg::omc_mode_t m);
    isRunning = (m == omc_pkg::OMC_ACTIVE) || (m == omc_pkg::OMC_CONNECTED);
  endfunction : isRunning

  function automatic logic isPoweredDown(input omc_pkg::omc_mode_t m);
    isPoweredDown = (m == omc_pkg::OMC_NOT_POWERED) || (m == omc_pkg::OMC_POWER_OFF);
  endfunction : isPoweredDown

  // power saving starts disabled and is forced off while powered down
  always_ff @(posedge mclk)
  begin
    if (srst)
      powerSaving <= omc_pkg::PSV_RESET;
    else if (clkEn)
    begin
      if (isPoweredDown(state))
        powerSaving <= omc_pkg::PSV_RESET;
      else if (regHit(regWr, regAddr, omc_pkg::REG_CONFIG))
        powerSaving <= regWdata[omc_pkg::CFG_PSV_LSB +: 2];
    end
  end

  // flow control keeps its value across power-down; writes ignored there
  always_ff @(posedge mclk)
  begin
    if (srst)
      flowControl <= omc_pkg::FLOW_RESET;
    else if (clkEn)
    begin
      if (!isPoweredDown(state) && regHit(regWr, regAddr, omc_pkg::REG_CONFIG))
        flowControl <= regWdata[omc_pkg::CFG_FLOW_LSB +: 2];
    end
  end

  // idle dwell counter for periodic wake
  always_ff @(posedge mclk)
  begin
    if (srst)
      idleCount <= '0;
    else if (clkEn)
    begin
      if (state != omc_pkg::OMC_IDLE || periodicWake)
        idleCount <= '0;
      else
        idleCount <= idleCount + 32'h1;
    end
  end

  // one-cycle wake at the end of the dwell
  assign periodicWake = (state == omc_pkg::OMC_IDLE) && (idleCount >= 32'(PAGING_PERIOD - 1));

  // wake sources, combined by OR
  always_comb
  begin
    wakeSrc    = '0;
    wakeSrc[0] = periodicWake;
    wakeSrc[1] = rtcAlarm;
    wakeSrc[2] = uartRxData && (powerSaving == omc_pkg::PSV_PERIODIC ||
                 flowControl != omc_pkg::FLOW_OFF);
    wakeSrc[3] = sRts && flowControl == omc_pkg::FLOW_OFF && powerSaving == omc_pkg::PSV_RTS;
    wakeSrc[4] = sDtr && powerSaving == omc_pkg::PSV_DTR;
    wakeSrc[5] = sUsbPres;
    wakeSrc[6] = usbRemoteWakeup;
    wakeSrc[7] = sPosReady;
    // spare cause bit, always clear
    wakeSrc[8] = 1'b0;
  end

  // mode transitions
  always_comb
  begin
    next_state = state;
    case (state)
      omc_pkg::OMC_NOT_POWERED:
      begin
        if (sSupply)
          next_state = omc_pkg::OMC_ACTIVE;
      end
      omc_pkg::OMC_POWER_OFF:
      begin
        if (!sSupply)
          next_state = omc_pkg::OMC_NOT_POWERED;
        else if (sSwitchOn || sReset || rtcAlarm)
          next_state = omc_pkg::OMC_ACTIVE;
      end
      omc_pkg::OMC_ACTIVE:
      begin
        if (!sSupply)
          next_state = omc_pkg::OMC_NOT_POWERED;
        else if (switchOffReq)
          next_state = omc_pkg::OMC_POWER_OFF;
        else if (callStart)
          next_state = omc_pkg::OMC_CONNECTED;
        // a live wake source or a missing slow clock keeps it awake
        else if (savingOn(powerSaving) && !activityBusy && slowClockPresent && ~|wakeSrc[7:1])
          next_state = omc_pkg::OMC_IDLE;
      end
      omc_pkg::OMC_IDLE:
      begin
        if (!sSupply)
          next_state = omc_pkg::OMC_NOT_POWERED;
        else if (|wakeSrc || !savingOn(powerSaving))
          next_state = omc_pkg::OMC_ACTIVE;
      end
      omc_pkg::OMC_CONNECTED:
      begin
        if (!sSupply)
          next_state = omc_pkg::OMC_NOT_POWERED;
        else if (callEnd)
          next_state = omc_pkg::OMC_ACTIVE;
      end
      default:
        next_state = omc_pkg::OMC_NOT_POWERED;
    endcase
  end

  // current mode register
  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= omc_pkg::OMC_NOT_POWERED;
    else if (clkEn)
      state <= next_state;
  end

  // latched wake cause, cleared by reading the wake register
  always_ff @(posedge mclk)
  begin
    if (srst)
      wakeCause <= '0;
    else if (clkEn)
    begin
      if (state == omc_pkg::OMC_IDLE && next_state == omc_pkg::OMC_ACTIVE)
        wakeCause <= wakeSrc;
      else if (regHit(regRd, regAddr, omc_pkg::REG_WAKE))
        wakeCause <= '0;
    end
  end

  // host-facing outputs
  // registered from the next state so they move together with mode
  logic next_ready;
  logic next_cts;
  always_comb
  begin
    next_ready = 1'b0;
    next_cts   = 1'b0;
    case (next_state)
      omc_pkg::OMC_ACTIVE, omc_pkg::OMC_CONNECTED:
      begin
        // periodic setting keeps the port usable while awake
        next_ready = !savingOn(powerSaving) || powerSaving == omc_pkg::PSV_PERIODIC;
        next_cts   = 1'b1;
      end
      omc_pkg::OMC_IDLE:
      begin
        next_ready = 1'b0;
        next_cts   = (flowControl == omc_pkg::FLOW_OFF);
      end
      default:
      begin
        next_ready = 1'b0;
        next_cts   = 1'b0;
      end
    endcase
  end

  // mode and clock reference follow the next state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mode         <= omc_pkg::OMC_NOT_POWERED;
      fastClockSel <= 1'b0;
    end
    else if (clkEn)
    begin
      mode         <= next_state;
      fastClockSel <= isRunning(next_state);
    end
  end

  // host-side readiness lines
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ifReady <= 1'b0;
      ctsOn   <= 1'b0;
    end
    else if (clkEn)
    begin
      ifReady <= next_ready;
      ctsOn   <= next_cts;
    end
  end

  // register read data, one cycle after strobe
  always_ff @(posedge mclk)
  begin
    if (srst)
      regRdata <= '0;
    else if (clkEn)
    begin
      regRdata <= '0;
      if (regRd)
      begin
        case (regAddr)
          omc_pkg::REG_CONFIG:
          begin
            regRdata[omc_pkg::CFG_PSV_LSB +: 2]  <= powerSaving;
            regRdata[omc_pkg::CFG_FLOW_LSB +: 2] <= flowControl;
          end
          omc_pkg::REG_STATUS:
          begin
            regRdata[omc_pkg::ST_MODE_LSB +: 3]  <= mode;
            regRdata[omc_pkg::ST_READY_BIT]      <= ifReady;
            regRdata[omc_pkg::ST_CTS_BIT]        <= ctsOn;
            regRdata[omc_pkg::ST_FAST_BIT]       <= fastClockSel;
          end
          omc_pkg::REG_WAKE:
            regRdata[omc_pkg::WAKE_SRC_N-1:0] <= wakeCause;
          default:
            regRdata <= '0;
        endcase
      end
    end
  end

endmodule : omc_operating_mode_controller

// ---- testbench/omc_chk.sv ----
// concurrent checks on the operating-mode controller ports
module omc_chk (
  input wire logic       mclk, srst, clkEn, supplyGood,
  input wire logic       switchOffReq, rtcAlarm, callStart, callEnd,
  input wire logic [2:0] mode,
  input wire logic       ifReady, ctsOn, fastClockSel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire live = clkEn && supplyGood;
  off_quiet_a: assert property (mode == 3'h1 |-> !ifReady && !ctsOn) else $error("port live when off");
  idle_quiet_a: assert property (mode == 3'h3 |-> !ifReady) else $error("ready in idle");
  fast_ref_a: assert property (fastClockSel == (mode == 3'h2 || mode == 3'h4)) else $error("bad clock ref");
  run_cts_a: assert property (mode inside {3'h2, 3'h4} |-> ctsOn) else $error("port shut while running");
  call_up_a: assert property (live && mode == 3'h2 && callStart && !switchOffReq |=> mode == 3'h4)
    else $error("call did not connect");
  call_down_a: assert property (live && mode == 3'h4 && callEnd |=> mode == 3'h2)
    else $error("call end missed");
  switch_off_a: assert property (live && mode == 3'h2 && switchOffReq |=> mode == 3'h1)
    else $error("switch-off missed");
  idle_alarm_a: assert property (live && mode == 3'h3 && rtcAlarm |=> mode == 3'h2)
    else $error("alarm did not wake");
  dead_stay_a: assert property (!supplyGood [*4] ##0 mode == 3'h0 |=> mode == 3'h0)
    else $error("woke without supply");
  supply_loss_a: assert property ($fell(supplyGood) && clkEn |-> ##[1:8] mode == 3'h0)
    else $error("supply loss missed");
  idle_c: cover property (mode == 3'h3);
  call_c: cover property (mode == 3'h4);
  off_c: cover property (mode == 3'h1);
endmodule : omc_chk

bind omc_operating_mode_controller omc_chk i_omc_chk (.mclk, .srst, .clkEn, .supplyGood, .switchOffReq,
  .rtcAlarm, .callStart, .callEnd, .mode, .ifReady, .ctsOn, .fastClockSel);

// ---- testbench/omc_host_model.sv ----
// host-side model driving the wake lines of the controller
module omc_host_model (
  // clock and commands from the bench
  input wire logic       mclk,
  input wire logic       wakeGo,
  input wire logic [2:0] wakeSel,
  input wire logic       slowOk,
  // host lines
  output logic           rtsOn, dtrOn, usbPresenceInput, usbRemoteWakeup,
  output logic           positioningReadyInput, slowClockPresent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold = 3'h0;
  logic [2:0] sel  = 3'h0;
  // a line stands ON for six cycles, then drops back to OFF
  always @(posedge mclk)
  begin
    if (wakeGo)
    begin
      hold <= 3'h6;
      sel  <= wakeSel;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign rtsOn                 = hold != 3'h0 && sel == 3'h3;
  assign dtrOn                 = hold != 3'h0 && sel == 3'h4;
  assign usbPresenceInput      = hold != 3'h0 && sel == 3'h5;
  assign usbRemoteWakeup       = hold != 3'h0 && sel == 3'h6;
  assign positioningReadyInput = hold != 3'h0 && sel == 3'h7;
  assign slowClockPresent      = slowOk;
endmodule : omc_host_model

// ---- testbench/omc_operating_mode_controller_tb.sv ----
// self-checking bench for the operating-mode controller
module omc_operating_mode_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 60;
  typedef struct packed {logic [1:0] psv, flow; logic [2:0] src; logic exp;} omc_row_t;
  logic mclk = '0, srst = '1, clkEn = '1, supplyGood = '0, switchOnInput = '0, resetInput_n = '1, slowOk = '1;
  logic switchOffReq = '0, rtcAlarm = '0, callStart = '0, callEnd = '0, activityBusy = '0, uartRxData = '0;
  logic regWr = '0, regRd = '0, wakeGo = '0, ifReady, ctsOn, fastClockSel;
  logic rtsOn, dtrOn, usbPresenceInput, usbRemoteWakeup, positioningReadyInput, slowClockPresent;
  logic [2:0] wakeSel = '0, mode;
  logic [3:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, rd;
  int errors = 0, comparisons = 0, k;
  // power saving, flow control, wake source (cause bit), wake expected
  omc_row_t rows [12] = '{'{2, 3, 3, 1}, '{2, 0, 3, 0}, '{1, 3, 3, 0}, '{3, 0, 4, 1}, '{2, 0, 4, 0},
    '{2, 0, 5, 1}, '{2, 0, 6, 1}, '{2, 0, 7, 1}, '{2, 0, 1, 1}, '{2, 0, 2, 1}, '{2, 3, 2, 0}, '{1, 3, 2, 1}};
  always #25 mclk = ~mclk;
  omc_operating_mode_controller #(.PAGING_PERIOD(PER)) i_omc_operating_mode_controller (.mclk, .srst, .clkEn,
    .supplyGood, .switchOnInput, .resetInput_n, .slowClockPresent, .switchOffReq, .rtcAlarm, .callStart,
    .callEnd, .activityBusy, .uartRxData, .usbRemoteWakeup, .rtsOn, .dtrOn, .usbPresenceInput,
    .positioningReadyInput, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .mode, .ifReady, .ctsOn, .fastClockSel);
  omc_host_model i_omc_host_model (.mclk, .wakeGo, .wakeSel, .slowOk, .rtsOn, .dtrOn, .usbPresenceInput,
    .usbRemoteWakeup, .positioningReadyInput, .slowClockPresent);
  task check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) {regWr, regAddr, regWdata} <= {1'h1, a, d};
    @(posedge mclk) regWr <= 1'h0;
  endtask : wr
  task rdr(input logic [3:0] a);
    @(posedge mclk) {regRd, regAddr} <= {1'h1, a};
    @(posedge mclk) regRd <= 1'h0;
    #1 rd = regRdata;
  endtask : rdr
  task waitm(input logic [2:0] m, input int n);
    k = 0;
    while (mode !== m && k < n)
    begin
      @(posedge mclk);
      #1 k++;
    end
  endtask : waitm
  // one-cycle event on {callStart, callEnd, switchOffReq}
  task pulse(input logic [2:0] v);
    @(posedge mclk) {callStart, callEnd, switchOffReq} <= v;
    @(posedge mclk) {callStart, callEnd, switchOffReq} <= 3'h0;
    #1;
  endtask : pulse
  initial
  begin
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    #1 check({ifReady, ctsOn, fastClockSel, mode}, 0);
    rdr(omc_pkg::REG_CONFIG);
    check(rd, 0);
    @(posedge mclk) switchOnInput <= 1'h1;
    waitm(3'h2, 8);
    check(mode, 0);
    @(posedge mclk) {supplyGood, switchOnInput} <= 2'h2;
    waitm(3'h2, 8);
    rdr(omc_pkg::REG_STATUS);
    check(rd, 32'h3A);
    rdr(4'hF);
    check(rd, 0);
    waitm(3'h3, 20);
    check(k, 20);
    foreach (rows[i])
    begin
      wr(omc_pkg::REG_CONFIG, {rows[i].flow, rows[i].psv});
      waitm(3'h3, 20);
      check({mode, ifReady, ctsOn}, {4'h6, rows[i].flow == omc_pkg::FLOW_OFF});
      @(posedge mclk) {wakeGo, wakeSel} <= {rows[i].src > 2, rows[i].src};
      {rtcAlarm, uartRxData} <= {rows[i].src == 1, rows[i].src == 2};
      @(posedge mclk) {wakeGo, rtcAlarm, uartRxData} <= '0;
      // a same-clock wake stands one cycle before idle returns, so look at once
      #1 waitm(3'h2, 12);
      check(k < 12, rows[i].exp);
      check(ifReady, rows[i].exp && rows[i].psv == omc_pkg::PSV_PERIODIC);
      check(ctsOn, rows[i].exp || rows[i].flow == omc_pkg::FLOW_OFF);
      rdr(omc_pkg::REG_WAKE);
      check(rd, rows[i].exp ? 32'h1 << rows[i].src : 0);
      wr(omc_pkg::REG_CONFIG, 0);
      waitm(3'h2, 20);
      rdr(omc_pkg::REG_WAKE);
    end
    wr(omc_pkg::REG_CONFIG, 1);
    waitm(3'h3, 20);
    waitm(3'h2, PER + 10);
    check(k > PER - 6 && k < PER + 6, 1);
    check(ifReady, 1);
    wr(omc_pkg::REG_CONFIG, 0);
    @(posedge mclk) {activityBusy, slowOk} <= 2'h3;
    wr(omc_pkg::REG_CONFIG, 2);
    waitm(3'h3, 20);
    check(k, 20);
    @(posedge mclk) {activityBusy, slowOk} <= 2'h0;
    waitm(3'h3, 20);
    check(k, 20);
    @(posedge mclk) slowOk <= 1'h1;
    wr(omc_pkg::REG_CONFIG, 0);
    pulse(3'h4);
    check({mode, fastClockSel}, 9);
    pulse(3'h2);
    check(mode, 2);
    for (int e = 0; e < 4; e++)
    begin
      repeat (4) @(posedge mclk);
      pulse(3'h1);
      check({mode, ifReady, ctsOn, fastClockSel}, 8);
      @(posedge mclk) {switchOnInput, resetInput_n, rtcAlarm, supplyGood} <= {e == 0, e != 1, e == 2, e != 3};
      waitm(3'h2, 8);
      check(mode, e == 3 ? 0 : 2);
      @(posedge mclk) {switchOnInput, resetInput_n, rtcAlarm, supplyGood} <= 4'h5;
      waitm(3'h2, 8);
    end
    check(mode, 2);
    complete_run();
  end
  initial
  begin
    repeat (6000) @(posedge mclk);
    errors++;
    complete_run();
  end
endmodule : omc_operating_mode_controller_tb
